// ===== verilog/hbfp_pkg.sv
// hbfp_pkg: constants shared by the bridge protection block.
// assumes a 125 MHz pclk and 32-bit apb data.
package hbfp_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned DEAD_TIME_NS    = 200;
	localparam int unsigned DEAD_CYC        = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned QUAL_TYP_NS     = 2000;
	localparam int unsigned QUAL_MIN_NS     = 1500;
	localparam int unsigned QUAL_MAX_NS     = 30000;
	// qualify time in ps = slope_ps * kohm + offset_ps
	localparam int unsigned QUAL_SLOPE_PS   = 88600;
	localparam int unsigned QUAL_OFFS_PS    = 58600;
	localparam int unsigned QUAL_RES_KOHM   = 22;
	localparam int unsigned QUAL_RES_MIN    = 16;
	localparam int unsigned QUAL_RES_MAX    = 337;
	localparam int unsigned QUAL_W          = 16;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CL = 8'h10;
	localparam logic [7:0] ADDR_QUAL   = 8'h14;

	// ==========================================================
	// field positions
	localparam int unsigned CTRL_A     = 0;
	localparam int unsigned CTRL_B     = 1;
	localparam int unsigned CTRL_EN    = 2;
	localparam int unsigned ST_THERM   = 0;
	localparam int unsigned ST_OVC     = 1;
	localparam int unsigned ST_LOW     = 2;
	localparam int unsigned ST_SLEEP   = 3;
	localparam int unsigned ST_FAULT   = 4;
	localparam int unsigned IRQ_W      = 3;
	localparam int unsigned IRQ_THERM  = 0;
	localparam int unsigned IRQ_OVC    = 1;
	localparam int unsigned IRQ_LOW    = 2;

	// ==========================================================
	// reset values
	localparam logic [2:0] CTRL_RST    = 3'h0;
	localparam logic [2:0] IRQ_EN_RST  = 3'h0;

	// leg driver states, gray along the usual path
	typedef enum logic [1:0] {
		HBFP_LEG_LOW  = 2'b00,
		HBFP_LEG_DEAD = 2'b01,
		HBFP_LEG_HIGH = 2'b11
	} hbfp_leg_t;

	// resistance in kohm to qualify cycles at the given clock
	function automatic logic [QUAL_W-1:0] qual_cycles(
		input logic [8:0] kohm
	);
		logic [31:0] ps;
		ps = 32'(kohm) * 32'(QUAL_SLOPE_PS) + 32'(QUAL_OFFS_PS);
		qual_cycles = QUAL_W'(ps / (32'd1000000 / 32'(CLK_MHZ)));
	endfunction : qual_cycles

endpackage : hbfp_pkg

// ===== verilog/hbfp_leg.sv
// hbfp_leg: one bridge leg with forced dead time on each level change.
// assumes the request comes from pclk logic; clear forces a quiet leg.
module hbfp_leg #(
	parameter int unsigned DEAD = hbfp_pkg::DEAD_CYC
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic clear,
	input  wire logic want_high,
	// gate drives
	output logic      gate_hi,
	output logic      gate_lo
);
	localparam int unsigned CW = $clog2(DEAD + 1);

	hbfp_pkg::hbfp_leg_t state_r;
	logic [CW-1:0]       cnt_r;
	logic                tgt_r;

	// ==========================================================
	// state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= hbfp_pkg::HBFP_LEG_DEAD;
			cnt_r   <= '0;
			tgt_r   <= 1'b0;
		end else if (clear) begin
			state_r <= hbfp_pkg::HBFP_LEG_DEAD;
			cnt_r   <= '0;
			tgt_r   <= 1'b0;
		end else begin
			unique case (state_r)
				hbfp_pkg::HBFP_LEG_LOW: begin
					if (want_high) begin
						state_r <= hbfp_pkg::HBFP_LEG_DEAD; // [R1]
						cnt_r   <= '0;
						tgt_r   <= 1'b1;
					end
				end
				hbfp_pkg::HBFP_LEG_HIGH: begin
					if (!want_high) begin
						state_r <= hbfp_pkg::HBFP_LEG_DEAD; // [R1]
						cnt_r   <= '0;
						tgt_r   <= 1'b0;
					end
				end
				hbfp_pkg::HBFP_LEG_DEAD: begin
					if (want_high != tgt_r) begin
						cnt_r <= '0;
						tgt_r <= want_high;
					end else if (cnt_r == CW'(DEAD - 1)) begin
						state_r <= tgt_r ? hbfp_pkg::HBFP_LEG_HIGH
							: hbfp_pkg::HBFP_LEG_LOW; // [R1]
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= hbfp_pkg::HBFP_LEG_DEAD;
				end
			endcase
		end
	end

	assign gate_hi = (state_r == hbfp_pkg::HBFP_LEG_HIGH);
	assign gate_lo = (state_r == hbfp_pkg::HBFP_LEG_LOW);

endmodule : hbfp_leg

// ===== verilog/hbfp_sync.sv
// hbfp_sync: two-flop synchroniser for an asynchronous level.
// assumes the level is stable for more than one pclk period.
module hbfp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// level
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	// ==========================================================
	// only q reads meta_r
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : hbfp_sync

// ===== verilog/hbfp_top.sv
// hbfp_top: protection and fault logic for a one-channel bridge.
// assumes comparator flags and power_down_n arrive asynchronously;
// software drives the wanted leg levels over apb.
//
// Functional notes
// [R1] each leg is fully off for 200 ns on every level change
// [R2] supply-low flag holds both outputs high impedance
// [R3] supply-low resets control and all protection state, clearing latches
// [R4] thermal flag forces both outputs high impedance
// [R5] thermal trip latches until supply low or power_down_n low then high
// [R6] overcurrent trips only after persisting the full qualify time
// [R7] overcurrent trip latches until supply low or power_down_n cycled
// [R8] qualify time 88.6 ns per kohm plus 58.6 ns, 1.5 to 30 us
// [R9] host must not release an overcurrent latch while the fault persists
// [R10] fault output high while thermal or overcurrent trip is latched
// [R11] power_down_n low gives off state; its rise resets and resumes
// [R12] fault output returns low when the latches are cleared
//
// Local design decisions: the placing of the registers and the APB register port.
module hbfp_top #(
	parameter int unsigned DEAD   = hbfp_pkg::DEAD_CYC,
	parameter logic [8:0]  RES_KOHM = 9'(hbfp_pkg::QUAL_RES_KOHM)
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog comparator flags and pins
	input  wire logic        supply_low_lockout,
	input  wire logic        thermal_trip,
	input  wire logic        overcurrent_trip,
	input  wire logic        power_down_n,
	// bridge gates and output enables
	output logic             bridge_out_a,
	output logic             bridge_out_a_oe,
	output logic             bridge_out_b,
	output logic             bridge_out_b_oe,
	// fault flag, open drain
	output logic             fault_o,
	output logic             fault_oe,
	output logic             irq
);
	// ==========================================================
	// synchronised inputs
	logic low_s;
	logic therm_s;
	logic ovc_s;
	logic pdn_s;

	hbfp_sync #(.RST_VAL(1'b1)) u_low (
		.pclk(pclk), .presetn(presetn),
		.d(supply_low_lockout), .q(low_s));
	hbfp_sync #(.RST_VAL(1'b0)) u_therm (
		.pclk(pclk), .presetn(presetn),
		.d(thermal_trip), .q(therm_s));
	hbfp_sync #(.RST_VAL(1'b0)) u_ovc (
		.pclk(pclk), .presetn(presetn),
		.d(overcurrent_trip), .q(ovc_s));
	hbfp_sync #(.RST_VAL(1'b0)) u_pdn (
		.pclk(pclk), .presetn(presetn),
		.d(power_down_n), .q(pdn_s));

	// ==========================================================
	// state clear: supply low or power-down held low
	logic pdn_d_r;
	logic wake;
	logic clr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdn_d_r <= 1'b0;
		end else begin
			pdn_d_r <= pdn_s;
		end
	end

	// the rise itself also clears, so latches start fresh on wake
	assign wake = pdn_s & ~pdn_d_r;
	assign clr  = low_s | ~pdn_s | wake; // [R3] [R11]

	// ==========================================================
	// apb decode
	logic       wr_en;
	logic       rd_en;
	logic       hit;
	logic [2:0] ctrl_r;
	logic [8:0] qual_kohm_r;
	logic [2:0] irq_st_r;
	logic [2:0] irq_en_r;

	always_comb begin
		unique case (paddr)
			hbfp_pkg::ADDR_CTRL,
			hbfp_pkg::ADDR_STATUS,
			hbfp_pkg::ADDR_IRQ_ST,
			hbfp_pkg::ADDR_IRQ_EN,
			hbfp_pkg::ADDR_IRQ_CL,
			hbfp_pkg::ADDR_QUAL: hit = 1'b1;
			default:             hit = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en   = psel & penable & pwrite & hit;
	assign rd_en   = psel & penable & ~pwrite;

	// ==========================================================
	// control register; reset by supply low or wake too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= hbfp_pkg::CTRL_RST;
		end else if (clr) begin
			ctrl_r <= hbfp_pkg::CTRL_RST; // [R3] [R11]
		end else if (wr_en && paddr == hbfp_pkg::ADDR_CTRL) begin
			ctrl_r <= pwdata[2:0];
		end
	end

	// setting resistance survives clears: it models a board part
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qual_kohm_r <= 9'(hbfp_pkg::QUAL_RES_KOHM);
		end else if (wr_en && paddr == hbfp_pkg::ADDR_QUAL) begin
			if (pwdata[8:0] < 9'(hbfp_pkg::QUAL_RES_MIN)) begin
				qual_kohm_r <= 9'(hbfp_pkg::QUAL_RES_MIN);
			end else if (pwdata[8:0] > 9'(hbfp_pkg::QUAL_RES_MAX)) begin
				qual_kohm_r <= 9'(hbfp_pkg::QUAL_RES_MAX);
			end else begin
				qual_kohm_r <= pwdata[8:0];
			end
		end
	end

	// ==========================================================
	// overcurrent qualification
	logic [hbfp_pkg::QUAL_W-1:0] qual_lim;
	logic [hbfp_pkg::QUAL_W-1:0] ovc_cnt_r;
	logic                        ovc_qual;

	assign qual_lim = hbfp_pkg::qual_cycles(qual_kohm_r); // [R8]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovc_cnt_r <= '0;
		end else if (clr || !ovc_s) begin
			ovc_cnt_r <= '0; // [R6]
		end else if (ovc_cnt_r != qual_lim) begin
			ovc_cnt_r <= ovc_cnt_r + 1'b1;
		end
	end

	assign ovc_qual = ovc_s && (ovc_cnt_r == qual_lim); // [R6]

	// ==========================================================
	// latched trips
	logic therm_lat_r;
	logic ovc_lat_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_lat_r <= 1'b0;
		end else if (clr) begin
			therm_lat_r <= 1'b0; // [R5] [R12]
		end else if (therm_s) begin
			therm_lat_r <= 1'b1; // [R4] [R5]
		end
	end

	// a host that releases while the load is still shorted just
	// re-trips after the qualify time; nothing here prevents it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovc_lat_r <= 1'b0;
		end else if (clr) begin
			ovc_lat_r <= 1'b0; // [R7] [R12] [R9]
		end else if (ovc_qual) begin
			ovc_lat_r <= 1'b1; // [R7]
		end
	end

	// ==========================================================
	// bridge legs
	logic off;
	logic a_hi;
	logic a_lo;
	logic b_hi;
	logic b_lo;

	assign off = clr | therm_lat_r | ovc_lat_r | ~ctrl_r[hbfp_pkg::CTRL_EN];

	hbfp_leg #(.DEAD(DEAD)) u_leg_a (
		.pclk(pclk), .presetn(presetn), .clear(off),
		.want_high(ctrl_r[hbfp_pkg::CTRL_A]),
		.gate_hi(a_hi), .gate_lo(a_lo));
	hbfp_leg #(.DEAD(DEAD)) u_leg_b (
		.pclk(pclk), .presetn(presetn), .clear(off),
		.want_high(ctrl_r[hbfp_pkg::CTRL_B]),
		.gate_hi(b_hi), .gate_lo(b_lo));

	// registered pin drive; high impedance is oe low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bridge_out_a    <= 1'b0;
			bridge_out_a_oe <= 1'b0;
			bridge_out_b    <= 1'b0;
			bridge_out_b_oe <= 1'b0;
		end else begin
			bridge_out_a    <= a_hi;
			bridge_out_a_oe <= ~off & (a_hi | a_lo); // [R2] [R4] [R1]
			bridge_out_b    <= b_hi;
			bridge_out_b_oe <= ~off & (b_hi | b_lo); // [R2] [R4] [R1]
		end
	end

	// ==========================================================
	// fault flag: open drain, released (high) on fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_oe <= 1'b1;
		end else begin
			fault_oe <= ~(therm_lat_r | ovc_lat_r); // [R10] [R12]
		end
	end

	assign fault_o = 1'b0;

	// ==========================================================
	// interrupts: set wins over clear
	logic [2:0] ev;
	logic [2:0] clr_w;

	assign ev[hbfp_pkg::IRQ_THERM] = therm_s & ~therm_lat_r & ~clr;
	assign ev[hbfp_pkg::IRQ_OVC]   = ovc_qual & ~ovc_lat_r & ~clr;
	assign ev[hbfp_pkg::IRQ_LOW]   = low_s;
	assign clr_w = (wr_en && paddr == hbfp_pkg::ADDR_IRQ_CL)
		? pwdata[2:0] : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_r <= 3'h0;
		end else begin
			irq_st_r <= (irq_st_r & ~clr_w) | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_r <= hbfp_pkg::IRQ_EN_RST;
		end else if (wr_en && paddr == hbfp_pkg::ADDR_IRQ_EN) begin
			irq_en_r <= pwdata[2:0];
		end
	end

	assign irq = |(irq_st_r & irq_en_r);

	// ==========================================================
	// read data, combinational in the access cycle
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0;
		unique case (paddr)
			hbfp_pkg::ADDR_CTRL:   rd_nxt[2:0] = ctrl_r;
			hbfp_pkg::ADDR_STATUS: begin
				rd_nxt[hbfp_pkg::ST_THERM] = therm_lat_r;
				rd_nxt[hbfp_pkg::ST_OVC]   = ovc_lat_r;
				rd_nxt[hbfp_pkg::ST_LOW]   = low_s;
				rd_nxt[hbfp_pkg::ST_SLEEP] = ~pdn_s;
				rd_nxt[hbfp_pkg::ST_FAULT] = therm_lat_r | ovc_lat_r;
			end
			hbfp_pkg::ADDR_IRQ_ST: rd_nxt[2:0] = irq_st_r;
			hbfp_pkg::ADDR_IRQ_EN: rd_nxt[2:0] = irq_en_r;
			hbfp_pkg::ADDR_QUAL:   rd_nxt[8:0] = qual_kohm_r;
			default:               rd_nxt = 32'h0;
		endcase
	end

	// prdata is combinational from registers so it is valid in the
	// single access cycle; zero outside reads
	assign prdata = rd_en ? rd_nxt : 32'h0;

endmodule : hbfp_top

// ===== test/hbfp_top_assertions.sv
// hbfp_top_assertions: protection checks on the ports of hbfp_top.
// assumes the bench sets the qualify resistor to 16 kohm (184 cycles).
module hbfp_top_assertions #(
	parameter int unsigned DEAD = 3
) (
	// clock, reset and apb
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	// flags and pins
	input wire logic       supply_low_lockout,
	input wire logic       thermal_trip,
	input wire logic       overcurrent_trip,
	input wire logic       power_down_n,
	input wire logic       bridge_out_a_oe,
	input wire logic       bridge_out_b_oe,
	input wire logic       fault_o,
	input wire logic       fault_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// helper counters, saturating
	logic [7:0] off_a_r;
	logic [7:0] off_b_r;
	logic [8:0] ovc_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_a_r <= 8'h00;
			off_b_r <= 8'h00;
		end else begin
			off_a_r <= bridge_out_a_oe ? 8'h00 : off_a_r + 8'(off_a_r != 8'hff);
			off_b_r <= bridge_out_b_oe ? 8'h00 : off_b_r + 8'(off_b_r != 8'hff);
		end
	end
	// sleep clears the overcurrent run as it clears the latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovc_r <= 9'h000;
		else
			ovc_r <= (overcurrent_trip && power_down_n) ?
				ovc_r + 9'(ovc_r != 9'h1ff) : 9'h000;
	end
	// ==========================================
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_sleep; !power_down_n [*5]; endsequence
	sequence s_low; supply_low_lockout [*5]; endsequence
	property p_dead_a; $rose(bridge_out_a_oe) |-> off_a_r >= 8'(DEAD); endproperty
	property p_dead_b; $rose(bridge_out_b_oe) |-> off_b_r >= 8'(DEAD); endproperty
	property p_low_off; s_low |-> !bridge_out_a_oe && !bridge_out_b_oe; endproperty
	property p_low_clear; s_low |-> fault_oe; endproperty
	property p_therm_off;
		thermal_trip [*5] |-> !bridge_out_a_oe && !bridge_out_b_oe;
	endproperty
	property p_latched;
		!fault_oe && !$past(fault_oe) |->
			!bridge_out_a_oe && !bridge_out_b_oe && !fault_o;
	endproperty
	property p_ovc_min; $fell(fault_oe) && overcurrent_trip |-> ovc_r >= 9'd184;
	endproperty
	property p_ovc_max; ovc_r == 9'd200 |-> !fault_oe; endproperty
	property p_sleep; s_sleep |-> fault_oe && !bridge_out_a_oe; endproperty
	property p_err; psel && penable && paddr == 8'hfc |-> pslverr && pready;
	endproperty
	a_dead_a: assert property (p_dead_a) else $error("leg a on early");
	a_dead_b: assert property (p_dead_b) else $error("leg b on early");
	a_low_off: assert property (p_low_off) else $error("driven in low");
	a_low_clear: assert property (p_low_clear) else $error("flag in low");
	a_therm_off: assert property (p_therm_off) else $error("hot drive");
	a_latched: assert property (p_latched) else $error("latch drive");
	a_ovc_min: assert property (p_ovc_min) else $error("early trip");
	a_ovc_max: assert property (p_ovc_max) else $error("no trip");
	a_sleep: assert property (p_sleep) else $error("sleep drive");
	a_err: assert property (p_err) else $error("no slave error");
endmodule : hbfp_top_assertions

bind hbfp_top hbfp_top_assertions #(.DEAD(DEAD)) i_hbfp_top_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.supply_low_lockout(supply_low_lockout), .thermal_trip(thermal_trip),
	.overcurrent_trip(overcurrent_trip), .power_down_n(power_down_n),
	.bridge_out_a_oe(bridge_out_a_oe), .bridge_out_b_oe(bridge_out_b_oe),
	.fault_o(fault_o), .fault_oe(fault_oe));

// ===== test/hbfp_host_model.sv
// hbfp_host_model: host side of the sleep pin and the fault flag.
// assumes the bench asks for wake and reports the load condition.
module hbfp_host_model (
	// requests
	input  wire logic pclk,
	input  wire logic wake,
	input  wire logic load_bad,
	// pins
	input  wire logic fault_o,
	input  wire logic fault_oe,
	output logic      power_down_n = 1'b0,
	output logic      fault_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// pull-up resolves the open-drain flag
	assign fault_line = fault_oe ? fault_o : 1'b1;
	// sleep follows wake at once; the rise waits for a sound load,
	// so a bad load never forces sleep by itself
	always @(posedge pclk)
		power_down_n <= wake && (power_down_n || !load_bad);
endmodule : hbfp_host_model

// ===== test/hbfp_top_test.sv
// hbfp_top_test: apb sequences with expected values for hbfp_top.
// assumes zero-wait apb and a short dead time parameter.
module hbfp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned DEAD = 3;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, low = 0, therm = 0, ovc = 0, wake = 0;
	logic        pdn, a, a_oe, b, b_oe, f_o, f_oe, irq, fault;
	int          mismatches = 0, tests_run = 0, cyc = 0, n;
	// ==========================================
	// design, host and clock
	hbfp_top #(.DEAD(DEAD)) i_hbfp_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_low_lockout(low), .thermal_trip(therm),
		.overcurrent_trip(ovc), .power_down_n(pdn), .bridge_out_a(a),
		.bridge_out_a_oe(a_oe), .bridge_out_b(b), .bridge_out_b_oe(b_oe),
		.fault_o(f_o), .fault_oe(f_oe), .irq(irq));
	hbfp_host_model i_hbfp_host_model (.pclk(pclk), .wake(wake),
		.load_bad(ovc), .fault_o(f_o), .fault_oe(f_oe),
		.power_down_n(pdn), .fault_line(fault));
	initial forever #4 pclk = ~pclk;
	// ==========================================
	// tasks
	task test_done;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		tests_run++;
		if (seen !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask : bus
	task rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
		bus(0, ad, 32'h0);
		chk(nm, rd, e);
	endtask : rdc
	task idle(input int k);
		repeat (k) @(posedge pclk);
		@(negedge pclk);
	endtask : idle
	task sleep_cycle;
		@(posedge pclk) wake <= 0;
		idle(6);
		@(posedge pclk) wake <= 1;
		idle(6);
	endtask : sleep_cycle
	// ==========================================
	// timeout, well above the run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done;
		end
	end
	// ==========================================
	// main sequence
	initial begin
		idle(10);
		@(posedge pclk) presetn <= 1;
		wake <= 1;
		idle(8);
		rdc("ctrl", hbfp_pkg::ADDR_CTRL, 32'h0);
		rdc("irq_en", hbfp_pkg::ADDR_IRQ_EN, 32'h0);
		rdc("qual", hbfp_pkg::ADDR_QUAL, 32'h16);
		bus(1, hbfp_pkg::ADDR_QUAL, 32'h5);
		rdc("qual_lo", hbfp_pkg::ADDR_QUAL, 32'h10);
		bus(1, hbfp_pkg::ADDR_QUAL, 32'h190);
		rdc("qual_hi", hbfp_pkg::ADDR_QUAL, 32'h151);
		bus(1, hbfp_pkg::ADDR_QUAL, 32'h10);
		rdc("unmapped", 8'hfc, 32'h0);
		bus(1, hbfp_pkg::ADDR_IRQ_EN, 32'h7);
		bus(1, hbfp_pkg::ADDR_CTRL, 32'h5);
		idle(DEAD + 6);
		chk("a_high", {a_oe, a, b_oe, b}, 4'b1110);
		bus(1, hbfp_pkg::ADDR_CTRL, 32'h6);
		while (a_oe === 1'b1) @(negedge pclk);
		n = 0;
		while (a_oe !== 1'b1) begin
			n++;
			@(negedge pclk);
		end
		chk("dead", n, DEAD);
		chk("a_low", a, 1'b0);
		chk("b_high", {b_oe, b}, 2'b11);
		@(posedge pclk) therm <= 1;
		idle(6);
		@(posedge pclk) therm <= 0;
		idle(2);
		chk("t_off", {a_oe, b_oe, fault}, 3'b001);
		idle(30);
		chk("t_latch", {a_oe, b_oe}, 2'b00);
		rdc("t_stat", hbfp_pkg::ADDR_STATUS, 32'h11);
		chk("irq_on", irq, 1'b1);
		bus(1, hbfp_pkg::ADDR_IRQ_EN, 32'h0);
		idle(1);
		chk("irq_mask", irq, 1'b0);
		bus(1, hbfp_pkg::ADDR_IRQ_EN, 32'h7);
		bus(1, hbfp_pkg::ADDR_IRQ_CL, 32'h7);
		rdc("irq_clr", hbfp_pkg::ADDR_IRQ_ST, 32'h0);
		sleep_cycle;
		chk("t_clear", fault, 1'b0);
		rdc("ctrl_wake", hbfp_pkg::ADDR_CTRL, 32'h0);
		// short overcurrent must not trip
		bus(1, hbfp_pkg::ADDR_CTRL, 32'h5);
		@(posedge pclk) ovc <= 1;
		idle(150);
		@(posedge pclk) ovc <= 0;
		idle(10);
		chk("o_short", {a_oe, fault}, 2'b10);
		@(posedge pclk) ovc <= 1;
		idle(210);
		chk("o_trip", {a_oe, fault}, 2'b01);
		rdc("o_stat", hbfp_pkg::ADDR_STATUS, 32'h12);
		@(posedge pclk) ovc <= 0;
		idle(10);
		chk("o_latch", {a_oe, fault}, 2'b01);
		sleep_cycle;
		chk("o_clear", fault, 1'b0);
		// supply low wipes a thermal latch and the control word
		bus(1, hbfp_pkg::ADDR_CTRL, 32'h5);
		@(posedge pclk) therm <= 1;
		idle(6);
		@(posedge pclk) therm <= 0;
		low <= 1;
		idle(6);
		chk("s_off", {a_oe, b_oe, fault}, 3'b000);
		bus(1, hbfp_pkg::ADDR_CTRL, 32'h5);
		rdc("s_ctrl", hbfp_pkg::ADDR_CTRL, 32'h0);
		rdc("s_stat", hbfp_pkg::ADDR_STATUS, 32'h04);
		@(posedge pclk) low <= 0;
		idle(8);
		rdc("s_irq", hbfp_pkg::ADDR_IRQ_ST, 32'h7);
		chk("s_irq_on", irq, 1'b1);
		test_done;
	end
endmodule : hbfp_top_test
